// ==== rtl/pvm_defs.svh ====
// Purpose: Constants for the peripheral interrupt vector map
// Assumes: One system clock, one asynchronous reset
// Notes:   Vector numbers are fixed by the device memory map
`ifndef PVM_DEFS_SVH
`define PVM_DEFS_SVH

// Vector count and width
// Twenty-six vector slots
`define PVM_NUM_VECTORS    26
`define PVM_VEC_W          5

// Vector numbers
// Reset slot, scan NMI
`define PVM_VEC_RESET      5'h00
`define PVM_VEC_SCAN_NMI   5'h01
`define PVM_VEC_VOLT_MON   5'h02
`define PVM_VEC_PORT_A     5'h03
`define PVM_VEC_PORT_B     5'h04
`define PVM_VEC_UNUSED     5'h05
`define PVM_VEC_RT_COUNT   5'h06
`define PVM_VEC_PERIODIC   5'h07
`define PVM_VEC_TMRA_OVF   5'h08
`define PVM_VEC_TMRA_HUNF  5'h09
`define PVM_VEC_TMRA_CMP0  5'h0A
`define PVM_VEC_TMRA_CMP1  5'h0B
`define PVM_VEC_TMRA_CMP2  5'h0C
`define PVM_VEC_TMRB       5'h0D
`define PVM_VEC_TMRD_OVF   5'h0E
`define PVM_VEC_TMRD_TRIG  5'h0F
`define PVM_VEC_COMPARATOR 5'h10
`define PVM_VEC_CONV_READY 5'h11
`define PVM_VEC_CONV_WIN   5'h12
`define PVM_VEC_TWI_SLAVE  5'h13
`define PVM_VEC_TWI_MASTER 5'h14
`define PVM_VEC_SPI        5'h15
`define PVM_VEC_SER_RXC    5'h16
`define PVM_VEC_SER_DRE    5'h17
`define PVM_VEC_SER_TXC    5'h18
`define PVM_VEC_NVM_READY  5'h19

// Sources that can really raise a flag (not reset, not vector 5)
`define PVM_SOURCE_MASK    26'h3FFFFDE
// Sources that pass regardless of the global enable
`define PVM_NMI_MASK       26'h0000002
// Reset value of all flags and of the vector output
`define PVM_FLAGS_RESET    26'h0000000
`define PVM_VEC_IDLE       5'h00

`endif

// ==== rtl/pvm_pkg.sv ====
// Purpose: Types for the peripheral interrupt vector map
// Assumes: pvm_defs.svh holds the numbers
// Notes:   All state of the top module is one packed struct
`include "pvm_defs.svh"

package pvm_pkg;

  // One bit per vector
  typedef logic [`PVM_NUM_VECTORS-1:0] pvm_vec_bits_t;

  // Vector number
  typedef logic [`PVM_VEC_W-1:0] pvm_vec_num_t;

  // Request presented to the core
  typedef struct packed {
    logic         valid;   // A request is pending
    pvm_vec_num_t vector;  // Lowest pending vector
  } pvm_core_req_t;

  // Whole state of the map
  typedef struct packed {
    pvm_vec_bits_t flags;  // Interrupt flag bits
    pvm_core_req_t req;    // Registered core request
  } pvm_state_t;

endpackage

// ==== rtl/pvm_vector_map.sv ====
// Purpose: Collect peripheral flags and present a vector to the core
// Assumes: Inputs synchronous to REF_CLK; peripherals clear flags
// Notes:   Core request lags the flag by one clock
`timescale 1ns/1ns
`include "pvm_defs.svh"

module pvm_vector_map #(
  parameter int NUM_VECTORS = `PVM_NUM_VECTORS  // Vector count
) (
  input  wire logic                          REF_CLK,        // System clock
  input  wire logic                          RST,            // Async reset, high
  input  wire pvm_pkg::pvm_vec_bits_t        SRC_EVENT,      // Condition pulses
  input  wire pvm_pkg::pvm_vec_bits_t        FLAG_CLEAR,     // Flag clear pulses
  input  wire pvm_pkg::pvm_vec_bits_t        ENABLE_BITS,    // Per-source enables
  input  wire logic                          GLOBAL_ENABLE,  // Global enable
  output logic        [NUM_VECTORS-1:0]      FLAGS,          // Flag register view
  output logic        [NUM_VECTORS-1:0]      REQ_LINES,      // Enabled requests
  output logic                               IRQ_VALID,      // Core request valid
  output pvm_pkg::pvm_vec_num_t              IRQ_VECTOR      // Core vector number
);

  // Elaboration check: the map is fixed at this count
  if (NUM_VECTORS != `PVM_NUM_VECTORS)
  begin : g_bad_count
    $error("pvm_vector_map supports only the fixed vector count");
  end

  pvm_pkg::pvm_state_t    state_reg;   // Registered state
  pvm_pkg::pvm_state_t    state_next;  // Next state
  pvm_pkg::pvm_vec_bits_t req_lines;   // Flag and enable per source
  pvm_pkg::pvm_vec_bits_t req_gated;   // After global gate

  // Masks as typed constants so single bits can be picked
  localparam pvm_pkg::pvm_vec_bits_t src_mask = `PVM_SOURCE_MASK;  // Real sources
  localparam pvm_pkg::pvm_vec_bits_t nmi_mask = `PVM_NMI_MASK;     // Global bypass

  // One slot per vector
  // Per-source request from flag and enable
  for (genvar g = 0; g < `PVM_NUM_VECTORS; g++)
  begin : g_src
    assign req_lines[g] = state_reg.flags[g] & ENABLE_BITS[g];
    assign req_gated[g] = req_lines[g] & (GLOBAL_ENABLE | nmi_mask[g]);
  end

  // Next state: flags and priority pick
  always_comb
  begin
    state_next = state_reg;
    // Event sets flag, set beats clear
    // Flag held until peripheral clears it
    state_next.flags = ((state_reg.flags & ~FLAG_CLEAR) | SRC_EVENT) & src_mask;
    state_next.req.valid  = 1'b0;
    state_next.req.vector = `PVM_VEC_IDLE;
    for (int i = `PVM_NUM_VECTORS - 1; i >= 0; i--)
    begin
      if (req_gated[i])
      begin
        state_next.req.valid  = 1'b1;
        state_next.req.vector = pvm_pkg::pvm_vec_num_t'(i);
      end
    end
  end

  // State register
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg.flags      <= `PVM_FLAGS_RESET;
      state_reg.req.valid  <= 1'b0;
      state_reg.req.vector <= `PVM_VEC_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs
  // Per-source enables applied to REQ_LINES and the core request, global enable to the core request only, neither to FLAGS
  assign FLAGS      = state_reg.flags;
  assign REQ_LINES  = req_lines;
  assign IRQ_VALID  = state_reg.req.valid;
  assign IRQ_VECTOR = state_reg.req.vector;

  // Assertions
  // Sequences for the flag life cycle
  sequence s_event_on_real_src(int k);
    SRC_EVENT[k] && src_mask[k];
  endsequence

  sequence s_flag_kept(int k);
    state_reg.flags[k] && !FLAG_CLEAR[k];
  endsequence

  property p_flag_set(int k);
    @(posedge REF_CLK) disable iff (RST)
    s_event_on_real_src(k) |=> FLAGS[k];
  endproperty

  property p_flag_hold(int k);
    @(posedge REF_CLK) disable iff (RST)
    s_flag_kept(k) |=> FLAGS[k];
  endproperty

  a_flag_set_port_a: assert property (p_flag_set(`PVM_VEC_PORT_A))
    else $error("port A flag not set by event");
  a_flag_set_nvm: assert property (p_flag_set(`PVM_VEC_NVM_READY))
    else $error("nonvolatile flag not set by event");
  a_flag_hold_timer: assert property (p_flag_hold(`PVM_VEC_TMRA_OVF))
    else $error("timer A flag dropped without clear");

  // Clear lands when no event competes
  a_flag_clear_works: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (FLAGS[`PVM_VEC_TMRB] && FLAG_CLEAR[`PVM_VEC_TMRB] && !SRC_EVENT[`PVM_VEC_TMRB])
    |=> !FLAGS[`PVM_VEC_TMRB])
    else $error("timer B flag survived its clear");

  // Reset slot and empty slot never flag
  a_reserved_never: assert property (
    @(posedge REF_CLK) disable iff (RST)
    !FLAGS[`PVM_VEC_RESET] && !FLAGS[`PVM_VEC_UNUSED])
    else $error("reset or unused vector raised a flag");

  // Closed gate passes only the scan NMI
  a_global_gate: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (!GLOBAL_ENABLE && !req_lines[`PVM_VEC_SCAN_NMI]) |=> !IRQ_VALID)
    else $error("maskable request passed without global enable");

  // Scan NMI outranks every other source
  a_nmi_bypass: assert property (
    @(posedge REF_CLK) disable iff (RST)
    req_lines[`PVM_VEC_SCAN_NMI] |=> (IRQ_VALID && IRQ_VECTOR == `PVM_VEC_SCAN_NMI))
    else $error("scan NMI not presented first");

  // Shown vector was pending, nothing lower was
  a_lowest_first: assert property (
    @(posedge REF_CLK) disable iff (RST)
    IRQ_VALID |-> (($past(req_gated) & ((26'h1 << IRQ_VECTOR) - 26'h1)) == 26'h0
                   && (($past(req_gated) >> IRQ_VECTOR) & 26'h1) == 26'h1))
    else $error("presented vector not the lowest pending");

  // Disabled source with its flag up is never shown
  a_enable_masks: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (FLAGS[`PVM_VEC_VOLT_MON] && !ENABLE_BITS[`PVM_VEC_VOLT_MON])
    |=> (!IRQ_VALID || IRQ_VECTOR != `PVM_VEC_VOLT_MON))
    else $error("disabled source still presented");

  // Vector stays inside the map, off the reset slot
  a_vector_range: assert property (
    @(posedge REF_CLK) disable iff (RST)
    IRQ_VALID |-> (IRQ_VECTOR <= `PVM_VEC_NVM_READY && IRQ_VECTOR != `PVM_VEC_RESET))
    else $error("vector out of range");

  // Both gates open for one source
  sequence s_gates_open(int k);
    ENABLE_BITS[k] && GLOBAL_ENABLE;
  endsequence

  sequence s_alone(int k);
    req_gated == (26'h1 << k);
  endsequence

  // Event, then flag, then core request
  property p_event_to_core(int k);
    @(posedge REF_CLK) disable iff (RST)
    (s_event_on_real_src(k) ##1 s_gates_open(k)) |=> IRQ_VALID;
  endproperty

  // Lone request shows its own number
  property p_vector_of(int k);
    @(posedge REF_CLK) disable iff (RST)
    s_alone(k) |=> (IRQ_VALID && IRQ_VECTOR == pvm_pkg::pvm_vec_num_t'(k));
  endproperty

  // Port A event reaches the core two edges on
  a_event_reaches_core: assert property (p_event_to_core(`PVM_VEC_PORT_A))
    else $error("port A event never reached the core");

  // Any gated request keeps the core request up
  a_request_level: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (req_gated != 26'h0) |=> IRQ_VALID)
    else $error("core request dropped while a flag stands");

  // No gated request, idle core request
  a_request_needs_both: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (req_gated == 26'h0) |=> (!IRQ_VALID && IRQ_VECTOR == `PVM_VEC_IDLE))
    else $error("core request without a gated source");

  // Flag never rises without its event
  a_flag_no_spurious: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (!FLAGS[`PVM_VEC_COMPARATOR] && !SRC_EVENT[`PVM_VEC_COMPARATOR])
    |=> !FLAGS[`PVM_VEC_COMPARATOR])
    else $error("comparator flag rose without an event");

  // Set beats a clear in the same cycle
  a_set_beats_clear: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (SRC_EVENT[`PVM_VEC_PERIODIC] && FLAG_CLEAR[`PVM_VEC_PERIODIC])
    |=> FLAGS[`PVM_VEC_PERIODIC])
    else $error("periodic flag lost to a clear");

  // Vector map, one lone request at a time
  // Scan NMI, monitor and ports
  a_map_scan_nmi: assert property (
    p_vector_of(`PVM_VEC_SCAN_NMI))
    else $error("scan NMI vector wrong");

  a_map_volt_mon: assert property (
    p_vector_of(`PVM_VEC_VOLT_MON))
    else $error("voltage monitor vector wrong");

  a_map_port_a: assert property (
    p_vector_of(`PVM_VEC_PORT_A))
    else $error("port A vector wrong");

  a_map_port_b: assert property (
    p_vector_of(`PVM_VEC_PORT_B))
    else $error("port B vector wrong");

  // Realtime counter pair
  a_map_rt_count: assert property (
    p_vector_of(`PVM_VEC_RT_COUNT))
    else $error("realtime counter vector wrong");

  a_map_periodic: assert property (
    p_vector_of(`PVM_VEC_PERIODIC))
    else $error("periodic timer vector wrong");

  // Timer A sources
  a_map_tmra_ovf: assert property (
    p_vector_of(`PVM_VEC_TMRA_OVF))
    else $error("timer A overflow vector wrong");

  a_map_tmra_hunf: assert property (
    p_vector_of(`PVM_VEC_TMRA_HUNF))
    else $error("timer A high underflow vector wrong");

  a_map_tmra_cmp0: assert property (
    p_vector_of(`PVM_VEC_TMRA_CMP0))
    else $error("timer A compare 0 vector wrong");

  a_map_tmra_cmp1: assert property (
    p_vector_of(`PVM_VEC_TMRA_CMP1))
    else $error("timer A compare 1 vector wrong");

  a_map_tmra_cmp2: assert property (
    p_vector_of(`PVM_VEC_TMRA_CMP2))
    else $error("timer A compare 2 vector wrong");

  // Timer B and timer D
  a_map_tmrb: assert property (
    p_vector_of(`PVM_VEC_TMRB))
    else $error("timer B vector wrong");

  a_map_tmrd_ovf: assert property (
    p_vector_of(`PVM_VEC_TMRD_OVF))
    else $error("timer D overflow vector wrong");

  a_map_tmrd_trig: assert property (
    p_vector_of(`PVM_VEC_TMRD_TRIG))
    else $error("timer D trigger vector wrong");

  // Comparator and converter
  a_map_comparator: assert property (
    p_vector_of(`PVM_VEC_COMPARATOR))
    else $error("comparator vector wrong");

  a_map_conv_ready: assert property (
    p_vector_of(`PVM_VEC_CONV_READY))
    else $error("converter ready vector wrong");

  a_map_conv_win: assert property (
    p_vector_of(`PVM_VEC_CONV_WIN))
    else $error("converter window vector wrong");

  // Two-wire, SPI and serial port
  a_map_twi_slave: assert property (
    p_vector_of(`PVM_VEC_TWI_SLAVE))
    else $error("two-wire slave vector wrong");

  a_map_twi_master: assert property (
    p_vector_of(`PVM_VEC_TWI_MASTER))
    else $error("two-wire master vector wrong");

  a_map_spi: assert property (
    p_vector_of(`PVM_VEC_SPI))
    else $error("SPI vector wrong");

  a_map_ser_rxc: assert property (
    p_vector_of(`PVM_VEC_SER_RXC))
    else $error("serial receive vector wrong");

  a_map_ser_dre: assert property (
    p_vector_of(`PVM_VEC_SER_DRE))
    else $error("serial data empty vector wrong");

  a_map_ser_txc: assert property (
    p_vector_of(`PVM_VEC_SER_TXC))
    else $error("serial transmit vector wrong");

  // Nonvolatile memory
  a_map_nvm_ready: assert property (
    p_vector_of(`PVM_VEC_NVM_READY))
    else $error("nonvolatile ready vector wrong");

endmodule

// ==== verif/pvm_core_model.sv ====
// Purpose: Core model that services vectored requests
// Assumes: Flags are cleared by a handler after entry latency
// Notes:   Holds off two cycles after a clear, matching request lag
`timescale 1ns/1ns

module pvm_core_model (
  input  wire logic                  REF_CLK,     // System clock
  input  wire logic                  RST,         // Reset, high
  input  wire logic                  IRQ_VALID,   // Request valid
  input  wire pvm_pkg::pvm_vec_num_t IRQ_VECTOR,  // Vector taken
  input  wire logic                  SVC_EN,      // Service on
  input  wire logic [3:0]            WAIT_CYC,    // Entry latency
  output pvm_pkg::pvm_vec_bits_t     CLR          // Flag clear pulse
);
  logic [3:0] cnt_reg;   // Cycles waited
  logic [1:0] hold_reg;  // Lag holdoff

  always_ff @(posedge REF_CLK or posedge RST)
    if (RST)
    begin
      cnt_reg  <= 4'h0;
      hold_reg <= 2'h0;
      CLR      <= '0;
    end
    else
    begin
      CLR <= '0;
      if (hold_reg != 2'h0)
        hold_reg <= hold_reg - 2'h1;
      else if (!IRQ_VALID || !SVC_EN)
        cnt_reg <= 4'h0;
      else if (cnt_reg < WAIT_CYC)
        cnt_reg <= cnt_reg + 4'h1;
      else
      begin
        CLR      <= 26'h1 << IRQ_VECTOR;
        cnt_reg  <= 4'h0;
        hold_reg <= 2'h2;
      end
    end
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the vector map
// Assumes: Inputs change on the falling edge
// Notes:   Core model clears flags as a handler would
`timescale 1ns/1ns

module tb_top;
  logic                   clk        = 1'b0;  // System clock
  logic                   rst        = 1'b1;  // Reset
  pvm_pkg::pvm_vec_bits_t ev         = '0;    // Events
  pvm_pkg::pvm_vec_bits_t clr        = '0;    // Bench clears
  pvm_pkg::pvm_vec_bits_t clr_core;           // Core clears
  pvm_pkg::pvm_vec_bits_t en         = '0;    // Enables
  logic                   gie        = 1'b0;  // Global enable
  logic                   svc        = 1'b0;  // Service on
  logic [3:0]             wait_cyc   = 4'h0;  // Core latency
  logic [25:0]            flags;              // Flag view
  logic [25:0]            req;                // Request lines
  logic                   irq_v;              // Core valid
  pvm_pkg::pvm_vec_num_t  irq_n;              // Core vector
  int                     num_errors = 0;     // Mismatches
  int                     n_checks   = 0;     // Comparisons

  // Clock
  initial
    forever #50 clk = ~clk;

  pvm_vector_map u_dut (.REF_CLK(clk), .RST(rst), .SRC_EVENT(ev),
    .FLAG_CLEAR(clr | clr_core), .ENABLE_BITS(en), .GLOBAL_ENABLE(gie),
    .FLAGS(flags), .REQ_LINES(req), .IRQ_VALID(irq_v), .IRQ_VECTOR(irq_n));

  pvm_core_model u_core (.REF_CLK(clk), .RST(rst), .IRQ_VALID(irq_v),
    .IRQ_VECTOR(irq_n), .SVC_EN(svc), .WAIT_CYC(wait_cyc), .CLR(clr_core));

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string what, input logic [25:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s exp=%h got=%h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Pulse events, then clear all flags
  task automatic pulse(input logic [25:0] e);
    ev = e;
    tick(1);
    ev = '0;
  endtask

  task automatic clear_all;
    clr = '1;
    tick(1);
    clr = '0;
    tick(2);
  endtask

  // Each vector alone, lowest to highest
  task automatic t_map;
    logic ok;
    en  = '1;
    gie = 1'b1;
    for (int n = 0; n < 26; n++)
    begin
      ok = (n != 0) && (n != 5);
      pulse(26'h1 << n);
      chk("flag", ok ? 26'h1 << n : 26'h0, flags);
      tick(1);
      chk("valid", 26'(ok), 26'(irq_v));
      chk("vector", ok ? 26'(n) : 26'h0, irq_n);
      clear_all();
    end
    $display("t_map done");
  endtask

  // Global gate, NMI bypass, priority, enable off
  task automatic t_gate;
    gie = 1'b0;
    pulse(26'h6);
    tick(1);
    chk("nmi", 26'h1, irq_n);
    chk("req", 26'h6, req);
    clr = 26'h2;
    tick(1);
    clr = '0;
    tick(1);
    chk("gated", 26'h0, irq_v);
    gie = 1'b1;
    pulse(26'h2000400);
    tick(1);
    chk("prio", 26'h2, irq_n);
    en = ~26'h4;
    tick(2);
    chk("kept", 26'h2000404, flags);
    chk("next", 26'hA, irq_n);
    en = '1;
    clear_all();
    $display("t_gate done");
  endtask

  // Set wins over clear; level holds
  task automatic t_hold;
    clr = 26'h80;
    pulse(26'h80);
    clr = '0;
    tick(5);
    chk("hold", 26'h80, flags);
    chk("holdv", 26'h7, irq_n);
    clear_all();
    chk("drop", 26'h0, irq_v);
    $display("t_hold done");
  endtask

  // Core clears flag, prompt then slow
  task automatic t_core;
    for (int d = 0; d < 4; d += 3)
    begin
      wait_cyc = 4'(d);
      svc = 1'b1;
      pulse(26'h400000);
      for (int i = 0; i < 20 && flags !== 26'h0; i++)
        tick(1);
      if (flags !== 26'h0)
      begin
        num_errors++;
        $display("BAD svc_wait exp=%h got=%h", 26'h0, flags);
      end
      tick(2);
      chk("svc", 26'h0, flags);
      chk("svcv", 26'h0, irq_v);
      svc = 1'b0;
    end
    $display("t_core done");
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk("rst", 26'h0, flags | irq_n);
    t_map();
    t_gate();
    t_hold();
    t_core();
    print_verdict();
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
